// ---- design/npc_codec.sv ----
`timescale 1ns/10ps
module npc_codec (
	input wire logic clock_i,
	input wire logic srst_i,
	// transmit request: identifier plus payload words, word 0 in the low bits
	input wire logic tx_req_i,
	input wire logic [7:0] tx_id_i,
	input wire logic [32*npc_pkg::TX_MAX_BYTES/4-1:0] tx_words_i,
	input wire logic tx_ready_i,
	output logic tx_busy_o,
	output logic tx_reject_o,
	output logic [7:0] tx_id_o,
	output logic [7:0] tx_len_o,
	output logic [7:0] tx_byte_o,
	output logic tx_valid_o,
	output logic tx_first_o,
	output logic tx_last_o,
	// receive stream from the deframer
	input wire logic rx_start_i,
	input wire logic [7:0] rx_id_i,
	input wire logic [7:0] rx_len_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_valid_i,
	input wire logic rx_last_i,
	output logic rx_drop_o,
	output logic aid_pos_upd_o,
	output logic aid_vel_upd_o,
	output logic [63:0] aid_lat_o,
	output logic [63:0] aid_lon_o,
	output logic [63:0] aid_hgt_o,
	output logic [95:0] aid_vel_ned_o,
	output logic [95:0] aid_pos_sd_o,
	output logic [95:0] aid_vel_sd_o
);
	localparam int TXW = 8 * npc_pkg::TX_MAX_BYTES;

	typedef enum logic [0:0] {TX_IDLE, TX_SEND} npc_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_RECV, RX_DROP} npc_rx_e;

	// lookups for both directions
	logic [7:0] tx_lut_len; // fixed length of requested id
	logic tx_lut_ok; // id belongs to the outgoing group
	logic [7:0] rx_lut_len; // fixed length of announced id
	logic rx_lut_ok; // id belongs to the aiding group

	npc_len_lut u_tx_lut (
		.id_i(tx_id_i),
		.len_o(tx_lut_len),
		.is_tx_o(tx_lut_ok),
		.is_rx_o()
	);
	npc_len_lut u_rx_lut (
		.id_i(rx_id_i),
		.len_o(rx_lut_len),
		.is_tx_o(),
		.is_rx_o(rx_lut_ok)
	);

	// transmit state
	npc_tx_e tx_st_ff, nxt_tx_st;
	logic [TXW-1:0] tx_data_ff, nxt_tx_data; // latched payload, byte k at bits 8k
	logic [7:0] tx_idx_ff, nxt_tx_idx; // index of the byte on the output
	logic [7:0] tx_id_ff, nxt_tx_id;
	logic [7:0] tx_len_ff, nxt_tx_len;
	logic [7:0] tx_byte_ff, nxt_tx_byte;
	logic tx_valid_ff, nxt_tx_valid;
	logic tx_first_ff, nxt_tx_first;
	logic tx_last_ff, nxt_tx_last;
	logic tx_reject_ff, nxt_tx_reject;

	// transmit next state: latch words, then walk bytes low to high
	always_comb begin
		nxt_tx_st = tx_st_ff;
		nxt_tx_data = tx_data_ff;
		nxt_tx_idx = tx_idx_ff;
		nxt_tx_id = tx_id_ff;
		nxt_tx_len = tx_len_ff;
		nxt_tx_byte = tx_byte_ff;
		nxt_tx_valid = tx_valid_ff;
		nxt_tx_first = tx_first_ff;
		nxt_tx_last = tx_last_ff;
		nxt_tx_reject = 1'b0;
		case (tx_st_ff)
			TX_IDLE: begin
				if (tx_req_i && tx_lut_ok) begin
					// word order of the caller is the field order of each layout
					nxt_tx_data = tx_words_i;
					nxt_tx_id = tx_id_i;
					nxt_tx_len = tx_lut_len;
					nxt_tx_idx = 8'h00;
					nxt_tx_byte = tx_words_i[7:0];
					nxt_tx_valid = 1'b1;
					nxt_tx_first = 1'b1;
					nxt_tx_last = 1'b0;
					nxt_tx_st = TX_SEND;
				end else if (tx_req_i) begin
					// identifiers outside the outgoing group are never framed
					nxt_tx_reject = 1'b1;
				end
			end
			TX_SEND: begin
				if (tx_ready_i) begin
					if (tx_last_ff) begin
						nxt_tx_valid = 1'b0;
						nxt_tx_last = 1'b0;
						nxt_tx_first = 1'b0;
						nxt_tx_st = TX_IDLE;
					end else begin
						// least significant byte of each float goes first
						nxt_tx_idx = tx_idx_ff + 8'h01;
						nxt_tx_byte = tx_data_ff[8*nxt_tx_idx +: 8];
						nxt_tx_first = 1'b0;
						nxt_tx_last = (nxt_tx_idx == tx_len_ff - 8'h01);
					end
				end
			end
			default: begin
				nxt_tx_st = TX_IDLE;
			end
		endcase
	end

	// transmit registers
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			tx_st_ff <= TX_IDLE;
			tx_data_ff <= '0;
			tx_idx_ff <= 8'h00;
			tx_id_ff <= 8'h00;
			tx_len_ff <= 8'h00;
			tx_byte_ff <= 8'h00;
			tx_valid_ff <= 1'b0;
			tx_first_ff <= 1'b0;
			tx_last_ff <= 1'b0;
			tx_reject_ff <= 1'b0;
		end else begin
			tx_st_ff <= nxt_tx_st;
			tx_data_ff <= nxt_tx_data;
			tx_idx_ff <= nxt_tx_idx;
			tx_id_ff <= nxt_tx_id;
			tx_len_ff <= nxt_tx_len;
			tx_byte_ff <= nxt_tx_byte;
			tx_valid_ff <= nxt_tx_valid;
			tx_first_ff <= nxt_tx_first;
			tx_last_ff <= nxt_tx_last;
			tx_reject_ff <= nxt_tx_reject;
		end
	end

	// receive state
	npc_rx_e rx_st_ff, nxt_rx_st;
	logic [7:0] stage_ff [0:npc_pkg::RX_MAX_BYTES-1]; // raw payload bytes
	logic [7:0] nxt_stage [0:npc_pkg::RX_MAX_BYTES-1];
	logic [7:0] rx_cnt_ff, nxt_rx_cnt; // bytes taken so far
	logic [7:0] rx_id_ff, nxt_rx_id;
	logic [7:0] rx_len_ff, nxt_rx_len;
	logic commit_ff, nxt_commit; // payload complete, decode next cycle
	logic rx_drop_ff, nxt_rx_drop;

	// receive next state: stage bytes, check count at the last one
	always_comb begin
		nxt_rx_st = rx_st_ff;
		nxt_stage = stage_ff;
		nxt_rx_cnt = rx_cnt_ff;
		nxt_rx_id = rx_id_ff;
		nxt_rx_len = rx_len_ff;
		nxt_commit = 1'b0;
		nxt_rx_drop = 1'b0;
		if (rx_start_i) begin
			// a new start abandons any packet still in flight
			nxt_rx_id = rx_id_i;
			nxt_rx_len = rx_len_i;
			nxt_rx_cnt = 8'h00;
			if (rx_lut_ok && (rx_len_i == rx_lut_len)) begin
				nxt_rx_st = RX_RECV;
			end else begin
				nxt_rx_st = RX_DROP;
				nxt_rx_drop = rx_lut_ok;
			end
		end else begin
			case (rx_st_ff)
				RX_IDLE: begin
					nxt_rx_st = RX_IDLE;
				end
				RX_RECV: begin
					if (rx_valid_i) begin
						if (rx_cnt_ff < rx_len_ff) begin
							nxt_stage[rx_cnt_ff[5:0]] = rx_byte_i;
						end
						nxt_rx_cnt = rx_cnt_ff + 8'h01;
						if (rx_last_i) begin
							// byte count must equal the fixed length exactly
							nxt_commit = (nxt_rx_cnt == rx_len_ff);
							nxt_rx_drop = (nxt_rx_cnt != rx_len_ff);
							nxt_rx_st = RX_IDLE;
						end else if (nxt_rx_cnt > rx_len_ff) begin
							nxt_rx_drop = 1'b1;
							nxt_rx_st = RX_DROP;
						end
					end
				end
				RX_DROP: begin
					// swallow the rest of a bad packet
					if (rx_valid_i && rx_last_i) begin
						nxt_rx_st = RX_IDLE;
					end
				end
				default: begin
					nxt_rx_st = RX_IDLE;
				end
			endcase
		end
	end

	// receive registers
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rx_st_ff <= RX_IDLE;
			rx_cnt_ff <= 8'h00;
			rx_id_ff <= 8'h00;
			rx_len_ff <= 8'h00;
			commit_ff <= 1'b0;
			rx_drop_ff <= 1'b0;
			for (int i = 0; i < npc_pkg::RX_MAX_BYTES; i++) begin
				stage_ff[i] <= 8'h00;
			end
		end else begin
			rx_st_ff <= nxt_rx_st;
			rx_cnt_ff <= nxt_rx_cnt;
			rx_id_ff <= nxt_rx_id;
			rx_len_ff <= nxt_rx_len;
			commit_ff <= nxt_commit;
			rx_drop_ff <= nxt_rx_drop;
			stage_ff <= nxt_stage;
		end
	end

	// little-endian single float at a byte offset of the staged payload
	function automatic logic [31:0] le32(input int ofs);
		le32 = {stage_ff[ofs + 3], stage_ff[ofs + 2], stage_ff[ofs + 1], stage_ff[ofs]};
	endfunction : le32

	// little-endian double float: upper word sits four bytes higher
	function automatic logic [63:0] le64(input int ofs);
		le64 = {le32(ofs + npc_pkg::FP32_BYTES), le32(ofs)};
	endfunction : le64

	// stored aiding values
	logic [63:0] lat_ff, nxt_lat, lon_ff, nxt_lon, hgt_ff, nxt_hgt;
	logic [95:0] vel_ff, nxt_vel, psd_ff, nxt_psd, vsd_ff, nxt_vsd;
	logic pos_upd_ff, nxt_pos_upd, vel_upd_ff, nxt_vel_upd;

	// decode a committed payload; the array is stable for this cycle
	always_comb begin
		nxt_lat = lat_ff;
		nxt_lon = lon_ff;
		nxt_hgt = hgt_ff;
		nxt_vel = vel_ff;
		nxt_psd = psd_ff;
		nxt_vsd = vsd_ff;
		nxt_pos_upd = 1'b0;
		nxt_vel_upd = 1'b0;
		if (commit_ff) begin
			case (rx_id_ff)
				npc_pkg::ID_EXT_POS_VEL: begin
					nxt_lat = le64(npc_pkg::OFS_LAT);
					nxt_lon = le64(npc_pkg::OFS_LON);
					nxt_hgt = le64(npc_pkg::OFS_HGT);
					for (int k = 0; k < 3; k++) begin
						nxt_vel[32*k +: 32] = le32(npc_pkg::OFS_PV_VEL + npc_pkg::FP32_BYTES * k);
						nxt_psd[32*k +: 32] = le32(npc_pkg::OFS_PV_SD + npc_pkg::FP32_BYTES * k);
						nxt_vsd[32*k +: 32] = le32(npc_pkg::OFS_PV_SD + npc_pkg::FP32_BYTES * (k + 3));
					end
					nxt_pos_upd = 1'b1;
					nxt_vel_upd = 1'b1;
				end
				npc_pkg::ID_EXT_POS: begin
					nxt_lat = le64(npc_pkg::OFS_LAT);
					nxt_lon = le64(npc_pkg::OFS_LON);
					nxt_hgt = le64(npc_pkg::OFS_HGT);
					for (int k = 0; k < 3; k++) begin
						nxt_psd[32*k +: 32] = le32(npc_pkg::OFS_P_SD + npc_pkg::FP32_BYTES * k);
					end
					nxt_pos_upd = 1'b1;
				end
				npc_pkg::ID_EXT_VEL: begin
					for (int k = 0; k < 3; k++) begin
						nxt_vel[32*k +: 32] = le32(npc_pkg::OFS_V_VEL + npc_pkg::FP32_BYTES * k);
						nxt_vsd[32*k +: 32] = le32(npc_pkg::OFS_V_SD + npc_pkg::FP32_BYTES * k);
					end
					nxt_vel_upd = 1'b1;
				end
				default: begin
					nxt_pos_upd = 1'b0;
				end
			endcase
		end
	end

	// aiding value registers
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			lat_ff <= 64'h0;
			lon_ff <= 64'h0;
			hgt_ff <= 64'h0;
			vel_ff <= 96'h0;
			psd_ff <= 96'h0;
			vsd_ff <= 96'h0;
			pos_upd_ff <= 1'b0;
			vel_upd_ff <= 1'b0;
		end else begin
			lat_ff <= nxt_lat;
			lon_ff <= nxt_lon;
			hgt_ff <= nxt_hgt;
			vel_ff <= nxt_vel;
			psd_ff <= nxt_psd;
			vsd_ff <= nxt_vsd;
			pos_upd_ff <= nxt_pos_upd;
			vel_upd_ff <= nxt_vel_upd;
		end
	end

	// outputs straight from flip-flops
	assign tx_busy_o = (tx_st_ff == TX_SEND);
	assign tx_reject_o = tx_reject_ff;
	assign tx_id_o = tx_id_ff;
	assign tx_len_o = tx_len_ff;
	assign tx_byte_o = tx_byte_ff;
	assign tx_valid_o = tx_valid_ff;
	assign tx_first_o = tx_first_ff;
	assign tx_last_o = tx_last_ff;
	assign rx_drop_o = rx_drop_ff;
	assign aid_pos_upd_o = pos_upd_ff;
	assign aid_vel_upd_o = vel_upd_ff;
	assign aid_lat_o = lat_ff;
	assign aid_lon_o = lon_ff;
	assign aid_hgt_o = hgt_ff;
	assign aid_vel_ned_o = vel_ff;
	assign aid_pos_sd_o = psd_ff;
	assign aid_vel_sd_o = vsd_ff;
endmodule : npc_codec

// ---- design/npc_len_lut.sv ----
`timescale 1ns/10ps
// maps a packet identifier to its fixed payload length and direction
module npc_len_lut (
	input wire logic [7:0] id_i,
	output logic [7:0] len_o,
	output logic is_tx_o,
	output logic is_rx_o
);
	// pure lookup; unknown identifiers get length zero and no direction
	always_comb begin
		len_o = 8'h00;
		is_tx_o = 1'b0;
		is_rx_o = 1'b0;
		case (id_i)
			npc_pkg::ID_EULER: begin
				len_o = npc_pkg::LEN_EULER;
				is_tx_o = 1'b1;
			end
			npc_pkg::ID_QUAT: begin
				len_o = npc_pkg::LEN_QUAT;
				is_tx_o = 1'b1;
			end
			npc_pkg::ID_ROTATION_MATRIX: begin
				len_o = npc_pkg::LEN_ROTATION_MATRIX;
				is_tx_o = 1'b1;
			end
			npc_pkg::ID_ANG_RATE: begin
				len_o = npc_pkg::LEN_ANG_RATE;
				is_tx_o = 1'b1;
			end
			npc_pkg::ID_ANG_ACCEL: begin
				len_o = npc_pkg::LEN_ANG_ACCEL;
				is_tx_o = 1'b1;
			end
			npc_pkg::ID_EXT_POS_VEL: begin
				len_o = npc_pkg::LEN_EXT_POS_VEL;
				is_rx_o = 1'b1;
			end
			npc_pkg::ID_EXT_POS: begin
				len_o = npc_pkg::LEN_EXT_POS;
				is_rx_o = 1'b1;
			end
			npc_pkg::ID_EXT_VEL: begin
				len_o = npc_pkg::LEN_EXT_VEL;
				is_rx_o = 1'b1;
			end
			default: begin
				len_o = 8'h00;
			end
		endcase
	end
endmodule : npc_len_lut

// ---- design/npc_pkg.sv ----
package npc_pkg;
	// packet identifiers, one byte each
	localparam logic [7:0] ID_EULER = 8'h27;
	localparam logic [7:0] ID_QUAT = 8'h28;
	localparam logic [7:0] ID_ROTATION_MATRIX = 8'h29;
	localparam logic [7:0] ID_ANG_RATE = 8'h2A;
	localparam logic [7:0] ID_ANG_ACCEL = 8'h2B;
	localparam logic [7:0] ID_EXT_POS_VEL = 8'h2C;
	localparam logic [7:0] ID_EXT_POS = 8'h2D;
	localparam logic [7:0] ID_EXT_VEL = 8'h2E;
	// fixed payload lengths in bytes
	localparam logic [7:0] LEN_EULER = 8'h0C;
	localparam logic [7:0] LEN_QUAT = 8'h10;
	localparam logic [7:0] LEN_ROTATION_MATRIX = 8'h24;
	localparam logic [7:0] LEN_ANG_RATE = 8'h0C;
	localparam logic [7:0] LEN_ANG_ACCEL = 8'h0C;
	localparam logic [7:0] LEN_EXT_POS_VEL = 8'h3C;
	localparam logic [7:0] LEN_EXT_POS = 8'h24;
	localparam logic [7:0] LEN_EXT_VEL = 8'h18;
	// largest payloads in each direction
	localparam int TX_MAX_BYTES = 36;
	localparam int RX_MAX_BYTES = 60;
	// byte offsets inside the aiding payloads
	localparam int OFS_LAT = 0;
	localparam int OFS_LON = 8;
	localparam int OFS_HGT = 16;
	localparam int OFS_PV_VEL = 24;
	localparam int OFS_PV_SD = 36;
	localparam int OFS_P_SD = 24;
	localparam int OFS_V_VEL = 0;
	localparam int OFS_V_SD = 12;
	// spacing of single and double precision fields
	localparam int FP32_BYTES = 4;
	localparam int FP64_BYTES = 8;
endpackage : npc_pkg

// ---- verif/npc_codec_checker.sv ----
`timescale 1ns/10ps
// port-level checks on the codec
module npc_codec_checker (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic tx_req_i,
	input wire logic [7:0] tx_id_i,
	input wire logic tx_ready_i,
	input wire logic tx_busy_o,
	input wire logic tx_reject_o,
	input wire logic [7:0] tx_id_o,
	input wire logic [7:0] tx_len_o,
	input wire logic [7:0] tx_byte_o,
	input wire logic tx_valid_o,
	input wire logic tx_first_o,
	input wire logic tx_last_o,
	input wire logic rx_start_i,
	input wire logic [7:0] rx_id_i,
	input wire logic [7:0] rx_len_i,
	input wire logic rx_drop_o,
	input wire logic aid_pos_upd_o,
	input wire logic aid_vel_upd_o,
	input wire logic [63:0] aid_lat_o,
	input wire logic [95:0] aid_vel_ned_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (srst_i);
	// fixed length per outgoing id
	function automatic logic [7:0] exp_len(input logic [7:0] id);
		case (id)
			8'h28: return 8'h10;
			8'h29: return 8'h24;
			default: return 8'h0C;
		endcase
	endfunction : exp_len
	// an accepted request and the opening byte it causes
	sequence s_take;
		tx_req_i && !tx_busy_o && tx_id_i inside {[8'h27:8'h2B]};
	endsequence
	sequence s_open;
		tx_valid_o && tx_first_o && tx_busy_o;
	endsequence
	a_take_opens: assert property (s_take |=> s_open ##0 tx_id_o == $past(tx_id_i)) else $error("no opening byte");
	a_bad_reject: assert property (tx_req_i && !tx_busy_o && !(tx_id_i inside {[8'h27:8'h2B]})
		|=> tx_reject_o && !tx_valid_o) else $error("bad id not rejected");
	a_len_table: assert property (tx_valid_o |-> tx_len_o == exp_len(tx_id_o)) else $error("wrong length");
	a_stall_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o)
		&& $stable(tx_first_o)) else $error("byte moved under stall");
	a_last_ends: assert property (tx_valid_o && tx_last_o && tx_ready_i |=> !tx_valid_o && !tx_busy_o)
		else $error("packet did not end");
	a_len_drop: assert property (rx_start_i && rx_id_i == 8'h2E && rx_len_i != 8'h18 |=> rx_drop_o)
		else $error("bad length kept");
	a_unknown_quiet: assert property (rx_start_i && !(rx_id_i inside {[8'h2C:8'h2E]}) |=> !rx_drop_o)
		else $error("unknown id dropped loudly");
	a_vel_upd: assert property ($changed(aid_vel_ned_o) |-> aid_vel_upd_o) else $error("silent velocity change");
	a_pos_upd: assert property ($changed(aid_lat_o) |-> aid_pos_upd_o) else $error("silent position change");
endmodule : npc_codec_checker
bind npc_codec npc_codec_checker chk_u (.clock_i, .srst_i, .tx_req_i, .tx_id_i, .tx_ready_i, .tx_busy_o,
	.tx_reject_o, .tx_id_o, .tx_len_o, .tx_byte_o, .tx_valid_o, .tx_first_o, .tx_last_o, .rx_start_i,
	.rx_id_i, .rx_len_i, .rx_drop_o, .aid_pos_upd_o, .aid_vel_upd_o, .aid_lat_o, .aid_vel_ned_o);

// ---- verif/npc_host_sink.sv ----
`timescale 1ns/10ps
// host side of the outgoing byte stream
module npc_host_sink (
	input wire logic clock_i,
	output logic ready_o
);
	integer seed = 32'hDA57; // own stream of stalls
	// single driver: ready is unknown only while reset is still applied
	// one stall in four so both prompt and slow acceptance happen
	always @(negedge clock_i) begin
		ready_o <= ($random(seed) & 3) != 0;
	end
endmodule : npc_host_sink

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	logic tx_req_i = 1'b0;
	logic [7:0] tx_id_i = 8'h00;
	logic [287:0] tx_words_i = '0;
	logic tx_ready_i, tx_busy_o, tx_reject_o, tx_valid_o, tx_first_o, tx_last_o;
	logic [7:0] tx_id_o, tx_len_o, tx_byte_o;
	logic rx_start_i = 1'b0, rx_valid_i = 1'b0, rx_last_i = 1'b0;
	logic [7:0] rx_id_i = 8'h00, rx_len_i = 8'h00, rx_byte_i = 8'h00;
	logic rx_drop_o, aid_pos_upd_o, aid_vel_upd_o;
	logic [63:0] aid_lat_o, aid_lon_o, aid_hgt_o;
	logic [95:0] aid_vel_ned_o, aid_pos_sd_o, aid_vel_sd_o;
	int bad_count = 0;
	int comparisons = 0;
	integer seed = 32'hDA57;
	logic [10:0] tx_q[$]; // reject, first, last, byte
	logic [482:0] rx_q[$]; // drop, pos, vel, then lat..vel sd
	logic [479:0] m_val = '0; // expected aiding values
	int lens[5] = '{12, 16, 36, 12, 12};
	npc_codec dut_u (.clock_i, .srst_i, .tx_req_i, .tx_id_i, .tx_words_i, .tx_ready_i, .tx_busy_o,
		.tx_reject_o, .tx_id_o, .tx_len_o, .tx_byte_o, .tx_valid_o, .tx_first_o, .tx_last_o, .rx_start_i,
		.rx_id_i, .rx_len_i, .rx_byte_i, .rx_valid_i, .rx_last_i, .rx_drop_o, .aid_pos_upd_o,
		.aid_vel_upd_o, .aid_lat_o, .aid_lon_o, .aid_hgt_o, .aid_vel_ned_o, .aid_pos_sd_o, .aid_vel_sd_o);
	npc_host_sink host_u (.clock_i(clock_i), .ready_o(tx_ready_i));
	initial forever #25 clock_i = ~clock_i;
	task automatic chk(input logic ok);
		comparisons++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("MISMATCH %0t result differs from note", $time);
		end
	endtask : chk
	task automatic stop_test();
		if (bad_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : stop_test
	// each visible result takes the oldest note
	always @(posedge clock_i) begin
		if (!srst_i && ((tx_valid_o && tx_ready_i) || tx_reject_o)) begin
			chk(tx_q.size() > 0 && tx_q[0] === (tx_reject_o ? 11'h400 : {1'b0, tx_first_o, tx_last_o, tx_byte_o}));
			if (tx_q.size() > 0) void'(tx_q.pop_front());
		end
		if (!srst_i && (rx_drop_o || aid_pos_upd_o || aid_vel_upd_o)) begin
			chk(rx_q.size() > 0 && rx_q[0] === {rx_drop_o, aid_pos_upd_o, aid_vel_upd_o, aid_lat_o, aid_lon_o,
				aid_hgt_o, aid_vel_ned_o, aid_pos_sd_o, aid_vel_sd_o});
			if (rx_q.size() > 0) void'(rx_q.pop_front());
		end
	end
	// bounded wait for the sender to go idle
	task automatic wait_idle();
		int n;
		n = 0;
		while (tx_busy_o !== 1'b0 && n < 200) begin
			@(negedge clock_i);
			n++;
		end
		// judge by the flag itself, so an idle reached on the last poll still passes
		if (tx_busy_o !== 1'b0) begin
			bad_count++;
			stop_test();
		end
	endtask : wait_idle
	// len zero means a refused id
	task automatic tx_send(input logic [7:0] id, input int len);
		wait_idle();
		for (int j = 0; j < 9; j++) tx_words_i[32*j +: 32] = $random(seed);
		tx_id_i = id;
		tx_req_i = 1'b1;
		if (len == 0) tx_q.push_back(11'h400);
		for (int k = 0; k < len; k++) tx_q.push_back({1'b0, k == 0, k == len - 1, tx_words_i[8*k +: 8]});
		@(negedge clock_i);
		tx_req_i = 1'b0;
		@(negedge clock_i);
	endtask : tx_send
	// kind: drop, pos, vel bits of the expected pulse; zero means silence
	task automatic rx_send(input logic [7:0] id, input logic [7:0] ln, input int nb, input logic [2:0] kind);
		logic [479:0] d;
		for (int j = 0; j < 15; j++) d[32*j +: 32] = $random(seed);
		if (kind[1]) m_val[479:288] = {d[63:0], d[127:64], d[191:128]};
		if (kind == 3'b011) m_val[287:0] = {d[287:192], d[383:288], d[479:384]};
		if (kind == 3'b010) m_val[191:96] = d[287:192];
		// velocities sit at the front of this payload, deviations behind them
		if (kind == 3'b001) {m_val[287:192], m_val[95:0]} = {d[95:0], d[191:96]};
		if (kind != 3'b000) rx_q.push_back({kind, m_val});
		rx_start_i = 1'b1;
		rx_id_i = id;
		rx_len_i = ln;
		@(negedge clock_i);
		rx_start_i = 1'b0;
		for (int k = 0; k < nb; k++) begin
			rx_valid_i = 1'b1;
			rx_byte_i = d[8*k +: 8];
			rx_last_i = (k == nb - 1);
			@(negedge clock_i);
		end
		rx_valid_i = 1'b0;
		rx_last_i = 1'b0;
		rx_byte_i = 8'($random(seed));
		repeat (4) @(negedge clock_i);
	endtask : rx_send
	initial begin
		repeat (5) @(posedge clock_i);
		@(negedge clock_i);
		srst_i = 1'b0;
		for (int i = 0; i < 5; i++) tx_send(8'h27 + i[7:0], lens[i]);
		tx_send(8'h2C, 0);
		tx_send(8'h26, 0);
		rx_send(8'h2C, 8'h3C, 60, 3'b011);
		rx_send(8'h2D, 8'h24, 36, 3'b010);
		rx_send(8'h2E, 8'h18, 24, 3'b001);
		rx_send(8'h2E, 8'h17, 0, 3'b100);
		rx_send(8'h2D, 8'h24, 35, 3'b100);
		// overflow: byte 37 is not the last, so the drop comes before the packet ends
		rx_send(8'h2D, 8'h24, 38, 3'b100);
		rx_send(8'h2F, 8'h10, 8, 3'b000);
		rx_send(8'h2E, 8'h18, 24, 3'b001);
		wait_idle();
		repeat (10) @(negedge clock_i);
		chk(tx_q.size() == 0 && rx_q.size() == 0);
		stop_test();
	end
endmodule : tb_top
